/* File: src/vafc_regs.svh */
/*
 * Named constants for the vector alignment and fault checker: feature bits,
 * boundaries, access sizes and register geometry.
 * Assumes it is included by bare name in every design file that needs it.
 */
`ifndef VAFC_REGS_SVH
`define VAFC_REGS_SVH

// ----------------------------------------------------------------------
// Identification
// ----------------------------------------------------------------------
`define VAFC_ID_LEAF         32'h0000_0007
`define VAFC_ID_SUBLEAF      32'h0000_0000
`define VAFC_ID_FEATURE_BIT  5

// ----------------------------------------------------------------------
// Register geometry
// ----------------------------------------------------------------------
`define VAFC_WIDE_BITS       256
`define VAFC_NARROW_BITS     128
`define VAFC_NUM_REGS        16
`define VAFC_IDX_BITS        4

// ----------------------------------------------------------------------
// Sizes in bytes, encoded as log2, and the user privilege level
// ----------------------------------------------------------------------
`define VAFC_LOG2_16         3'h4
`define VAFC_LOG2_32         3'h5
`define VAFC_PRIV_USER       2'h3

`endif

/* File: src/vafc_pkg.sv */
/*
 * Types shared by the vector alignment and fault checker.
 * Assumes no other package; constants live in vafc_regs.svh.
 */
package vafc_pkg;

	// Encoding class of the instruction
	typedef enum logic [0:0] {
		VAFC_ENC_LEGACY,
		VAFC_ENC_PREFIXED
	} vafc_enc_t;

	// Memory behaviour class
	typedef enum logic [1:0] {
		VAFC_CLS_ALIGNED_MOVE,
		VAFC_CLS_UNALIGNED_MOVE,
		VAFC_CLS_ARITH,
		VAFC_CLS_SMALL
	} vafc_cls_t;

	// Floating-point exception source
	typedef enum logic [1:0] {
		VAFC_FP_BASE,
		VAFC_FP_CONV_FUSED,
		VAFC_FP_SECOND_GEN
	} vafc_fpsrc_t;

	typedef enum logic [2:0] {
		VAFC_FLT_NONE,
		VAFC_FLT_GP,
		VAFC_FLT_AC,
		VAFC_FLT_XM,
		VAFC_FLT_UD
	} vafc_fault_t;

endpackage : vafc_pkg

/* File: src/vafc_align_check.sv */
/*
 * Combinational alignment decision for one vector memory access.
 * Assumes the caller registers the results.
 */
`timescale 1ns/100ps
`include "vafc_regs.svh"

module vafc_align_check
	import vafc_pkg::*;
(
	input  wire logic [5:0] addrLow,
	input  wire vafc_enc_t  enc,
	input  wire vafc_cls_t  cls,
	input  wire logic [2:0] sizeLog2,
	input  wire logic       flagAlignCheck,
	input  wire logic [1:0] privLevel,
	input  wire logic       crAlignMask,
	output logic            gpFault,
	output logic            acFault
);

	// Low bits below the boundary must be zero
	function automatic logic misaligned(input logic [5:0] a,
		input logic [2:0] lg);
		logic [5:0] mask;
		mask = 6'h3f >> (3'h6 - lg);
		misaligned = |(a & mask);
	endfunction : misaligned

	wire logic        acEnabled;
	wire logic        wide;
	wire logic [2:0]  reqLog2;
	wire logic        alignedGp;
	wire logic        arithGp;

	assign wide      = sizeLog2 >= `VAFC_LOG2_16;
	// 32-byte forms need a 32-byte boundary
	assign reqLog2   = (sizeLog2 == `VAFC_LOG2_32) ? `VAFC_LOG2_32
		: `VAFC_LOG2_16;
	assign alignedGp = (cls == VAFC_CLS_ALIGNED_MOVE)
		&& misaligned(addrLow, reqLog2);
	// Prefixed arithmetic tolerates any byte address
	assign arithGp   = (cls == VAFC_CLS_ARITH) && (enc == VAFC_ENC_LEGACY)
		&& misaligned(addrLow, `VAFC_LOG2_16);
	assign gpFault   = alignedGp || arithGp;
	assign acEnabled = flagAlignCheck && crAlignMask
		&& (privLevel == `VAFC_PRIV_USER);
	// Wide references never trap on alignment check
	assign acFault   = acEnabled && !wide && !gpFault
		&& misaligned(addrLow, sizeLog2);

endmodule : vafc_align_check

/* File: src/vafc_vreg_file.sv */
/*
 * Wide vector register file with narrow aliasing and zero-upper writes.
 * Assumes one write and one read index per cycle on a single clock.
 */
`timescale 1ns/100ps
`include "vafc_regs.svh"

module vafc_vreg_file
	import vafc_pkg::*;
#(
	parameter int NUM_REGS = `VAFC_NUM_REGS
) (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         wrEn,
	input  wire logic [`VAFC_IDX_BITS-1:0]    wrIdx,
	input  wire logic [`VAFC_WIDE_BITS-1:0]   wrData,
	input  wire logic                         wrWide,
	input  wire vafc_enc_t                    wrEnc,
	input  wire logic [`VAFC_IDX_BITS-1:0]    rdIdx,
	output logic [`VAFC_WIDE_BITS-1:0]        rdWide,
	output logic [`VAFC_NARROW_BITS-1:0]      rdNarrow
);

	logic [`VAFC_WIDE_BITS-1:0] regs [NUM_REGS];
	wire  logic [`VAFC_WIDE_BITS-1:0] next_entry;
	wire  logic [`VAFC_NARROW_BITS-1:0] keepUpper;

	// Legacy narrow writes keep upper half; prefixed narrow writes clear it
	assign keepUpper  = (wrEnc == VAFC_ENC_LEGACY)
		? regs[wrIdx][`VAFC_WIDE_BITS-1:`VAFC_NARROW_BITS]
		: {`VAFC_NARROW_BITS{1'b0}};
	assign next_entry = wrWide ? wrData
		: {keepUpper, wrData[`VAFC_NARROW_BITS-1:0]};
	assign rdNarrow   = regs[rdIdx][`VAFC_NARROW_BITS-1:0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= '0;
			end
			rdWide <= '0;
		end else begin
			if (wrEn) begin
				regs[wrIdx] <= next_entry;
			end
			rdWide <= regs[rdIdx];
		end
	end

endmodule : vafc_vreg_file

/* File: src/vafc_top.sv */
/*
 * Vector alignment and fault checker top: alignment faults, floating-point
 * fault routing, identification feature bit and the vector register file.
 * Assumes the core presents one checked access per cycle on a valid strobe
 * and that all control inputs come from logic on clk.
 */
// How it works
// - Leaf seven subleaf zero returns bit five.
// - Narrow register aliases low half of wide.
// - Legacy 128-bit writes leave upper half untouched.
// - Prefixed 128-bit writes clear upper half.
// - 256-bit prefix reads and writes upper half.
// - Save and restore carry upper bits.
// - Legacy aligned moves fault if misaligned.
// - Legacy unaligned moves accept any address.
// - Legacy arithmetic 16-byte misaligned raises protection.
// - Prefixed arithmetic accepts any byte address.
// - Prefixed aligned moves need 16 or 32.
// - Small misaligned faults only when checks enabled.
// - 16 and 32-byte references never alignment-fault.
// - Prefixed FP faults follow legacy mask rules.
// - Without OS handler, unmasked FP gives undefined.
// - Conversion and fused ops follow same rules.
// - Second-generation FP ops never raise FP fault.
// - No extra atomicity for prefixed accesses.
`timescale 1ns/100ps
`include "vafc_regs.svh"

module vafc_top
	import vafc_pkg::*;
#(
	parameter int NUM_REGS  = `VAFC_NUM_REGS,
	parameter int FP_FLAGS  = 6
) (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// ------------------------------------------------------------------
	// Access check request
	// ------------------------------------------------------------------
	input  wire logic                         accValid,
	input  wire logic [5:0]                   accAddrLow,
	input  wire vafc_enc_t                    accEnc,
	input  wire vafc_cls_t                    accCls,
	input  wire logic [2:0]                   accSizeLog2,
	input  wire logic                         flagAlignCheck,
	input  wire logic [1:0]                   privLevel,
	input  wire logic                         crAlignMask,
	// ------------------------------------------------------------------
	// Floating-point exception request
	// ------------------------------------------------------------------
	input  wire logic                         fpValid,
	input  wire vafc_fpsrc_t                  fpSrc,
	input  wire logic [FP_FLAGS-1:0]          fpRaised,
	input  wire logic [FP_FLAGS-1:0]          fpMask,
	input  wire logic                         osSimdFpHandlerEnable,
	// ------------------------------------------------------------------
	// Identification query
	// ------------------------------------------------------------------
	input  wire logic                         idValid,
	input  wire logic [31:0]                  idLeaf,
	input  wire logic [31:0]                  idSubleaf,
	output logic [31:0]                       idEbx,
	output logic                              idDone,
	// ------------------------------------------------------------------
	// Register file port
	// ------------------------------------------------------------------
	input  wire logic                         wrEn,
	input  wire logic [`VAFC_IDX_BITS-1:0]    wrIdx,
	input  wire logic [`VAFC_WIDE_BITS-1:0]   wrData,
	input  wire logic                         wrWide,
	input  wire vafc_enc_t                    wrEnc,
	input  wire logic [`VAFC_IDX_BITS-1:0]    rdIdx,
	output logic [`VAFC_WIDE_BITS-1:0]        rdWide,
	output logic [`VAFC_NARROW_BITS-1:0]      rdNarrow,
	// ------------------------------------------------------------------
	// Fault outputs
	// ------------------------------------------------------------------
	output logic                              faultValid,
	output vafc_fault_t                       faultKind,
	output logic [15:0]                       faultCode
);

	// ------------------------------------------------------------------
	// Alignment decision
	// ------------------------------------------------------------------
	wire logic gpHit;
	wire logic acHit;

	vafc_align_check u_align (
		.addrLow        (accAddrLow),
		.enc            (accEnc),
		.cls            (accCls),
		.sizeLog2       (accSizeLog2),
		.flagAlignCheck (flagAlignCheck),
		.privLevel      (privLevel),
		.crAlignMask    (crAlignMask),
		.gpFault        (gpHit),
		.acFault        (acHit)
	);

	// ------------------------------------------------------------------
	// Floating-point routing
	// ------------------------------------------------------------------
	wire logic fpUnmasked;
	wire logic fpEligible;
	wire logic fpTrap;

	// Base and conversion/fused ops share one path
	assign fpEligible =
		fpSrc != VAFC_FP_SECOND_GEN;
	assign fpUnmasked = |(fpRaised & ~fpMask);
	assign fpTrap     = fpValid && fpEligible && fpUnmasked;

	// ------------------------------------------------------------------
	// Fault selection
	// ------------------------------------------------------------------
	// Memory faults win over FP: an access that traps never computes.
	// Accesses are checked only; atomic width is unchanged here.
	wire vafc_fault_t next_faultKind;
	wire logic        next_faultValid;

	assign next_faultKind =
		(accValid && gpHit) ? VAFC_FLT_GP
		: (accValid && acHit) ? VAFC_FLT_AC
		: !fpTrap ? VAFC_FLT_NONE
		: osSimdFpHandlerEnable ? VAFC_FLT_XM
		: VAFC_FLT_UD;
	assign next_faultValid = next_faultKind != VAFC_FLT_NONE;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			faultValid <= 1'b0;
			faultKind  <= VAFC_FLT_NONE;
			faultCode  <= 16'h0000;
		end else begin
			faultValid <= next_faultValid;
			faultKind  <= next_faultKind;
			faultCode  <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Identification
	// ------------------------------------------------------------------
	wire logic        leafHit;
	wire logic [31:0] next_idEbx;

	assign leafHit    = (idLeaf == `VAFC_ID_LEAF)
		&& (idSubleaf == `VAFC_ID_SUBLEAF);
	assign next_idEbx = leafHit ? (32'h0000_0001 << `VAFC_ID_FEATURE_BIT)
		: 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idEbx  <= 32'h0000_0000;
			idDone <= 1'b0;
		end else begin
			idDone <= idValid;
			if (idValid) begin
				idEbx <= next_idEbx;
			end
		end
	end

	// ------------------------------------------------------------------
	// Vector registers
	// ------------------------------------------------------------------
	vafc_vreg_file #(
		.NUM_REGS (NUM_REGS)
	) u_vregs (
		.clk      (clk),
		.rst_n    (rst_n),
		.wrEn     (wrEn),
		.wrIdx    (wrIdx),
		.wrData   (wrData),
		.wrWide   (wrWide),
		.wrEnc    (wrEnc),
		.rdIdx    (rdIdx),
		.rdWide   (rdWide),
		.rdNarrow (rdNarrow)
	);

endmodule : vafc_top

/* File: tb/vafc_assertions.sv */
/*
 * Port-level checker for the vector alignment and fault checker top.
 * Assumes it is bound to vafc_top and sees only that module's ports.
 */
`timescale 1ns/100ps
`include "vafc_regs.svh"

module vafc_assertions
	import vafc_pkg::*;
#(
	parameter int NUM_REGS = 16,
	parameter int FP_FLAGS = 6
) (
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire logic                       accValid,
	input wire logic [5:0]                 accAddrLow,
	input wire vafc_enc_t                  accEnc,
	input wire vafc_cls_t                  accCls,
	input wire logic [2:0]                 accSizeLog2,
	input wire logic                       flagAlignCheck,
	input wire logic [1:0]                 privLevel,
	input wire logic                       crAlignMask,
	input wire logic                       fpValid,
	input wire vafc_fpsrc_t                fpSrc,
	input wire logic [FP_FLAGS-1:0]        fpRaised,
	input wire logic [FP_FLAGS-1:0]        fpMask,
	input wire logic                       osSimdFpHandlerEnable,
	input wire logic                       idValid,
	input wire logic [31:0]                idLeaf,
	input wire logic [31:0]                idSubleaf,
	input wire logic [31:0]                idEbx,
	input wire logic                       idDone,
	input wire logic                       wrEn,
	input wire logic [`VAFC_IDX_BITS-1:0]  rdIdx,
	input wire logic [`VAFC_WIDE_BITS-1:0] rdWide,
	input wire logic [`VAFC_NARROW_BITS-1:0] rdNarrow,
	input wire logic                       faultValid,
	input wire vafc_fault_t                faultKind,
	input wire logic [15:0]                faultCode
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire logic misSize = |(accAddrLow & ~(6'h3f << accSizeLog2));
	wire logic acOn = flagAlignCheck && crAlignMask && privLevel == 2'h3;
	wire logic fpTrap = fpValid && fpSrc != VAFC_FP_SECOND_GEN
		&& |(fpRaised & ~fpMask);

	sequence s_gp;
		faultValid && faultKind == VAFC_FLT_GP && faultCode == 16'h0;
	endsequence
	sequence s_idHit;
		idValid && idLeaf == 32'h7 && idSubleaf == 32'h0;
	endsequence

	property p_idHit;
		s_idHit |=> idDone && idEbx == 32'h20;
	endproperty
	a_idHit: assert property (p_idHit)
		else $error("feature bit missing");
	property p_idMiss;
		idValid && !(idLeaf == 32'h7 && idSubleaf == 32'h0)
			|=> idDone && idEbx == 32'h0;
	endproperty
	a_idMiss: assert property (p_idMiss)
		else $error("stray id bits");
	property p_alignGp;
		accValid && accCls == VAFC_CLS_ALIGNED_MOVE && (accAddrLow[3:0] != 4'h0
			|| (accSizeLog2 == 3'h5 && accAddrLow[4])) |=> s_gp;
	endproperty
	a_alignGp: assert property (p_alignGp)
		else $error("aligned move no gp");
	property p_arithGp;
		accValid && accEnc == VAFC_ENC_LEGACY && accCls == VAFC_CLS_ARITH
			&& accAddrLow[3:0] != 4'h0 |=> s_gp;
	endproperty
	a_arithGp: assert property (p_arithGp)
		else $error("arith no gp");
	property p_freeNoGp;
		accValid && (accCls == VAFC_CLS_UNALIGNED_MOVE || (accCls ==
			VAFC_CLS_ARITH && accEnc == VAFC_ENC_PREFIXED))
			|=> faultKind != VAFC_FLT_GP;
	endproperty
	a_freeNoGp: assert property (p_freeNoGp)
		else $error("unaligned gp");
	property p_acHit;
		accValid && accCls == VAFC_CLS_SMALL && accSizeLog2 < 3'h4 && misSize
			&& acOn |=> faultValid && faultKind == VAFC_FLT_AC;
	endproperty
	a_acHit: assert property (p_acHit)
		else $error("missing ac");
	property p_acOff;
		accValid && !acOn |=> faultKind != VAFC_FLT_AC;
	endproperty
	a_acOff: assert property (p_acOff)
		else $error("ac while off");
	property p_noAcWide;
		accValid && accSizeLog2 >= 3'h4 |=> faultKind != VAFC_FLT_AC;
	endproperty
	a_noAcWide: assert property (p_noAcWide)
		else $error("wide ac");
	property p_fpTrap;
		fpTrap && !accValid |=> faultValid && faultKind ==
			($past(osSimdFpHandlerEnable) ? VAFC_FLT_XM : VAFC_FLT_UD);
	endproperty
	a_fpTrap: assert property (p_fpTrap)
		else $error("fp trap kind");
	property p_fpGen2;
		fpValid && fpSrc == VAFC_FP_SECOND_GEN && !accValid |=> !faultValid;
	endproperty
	a_fpGen2: assert property (p_fpGen2)
		else $error("gen2 fp fault");
	property p_alias;
		$stable(rdIdx) && !$past(wrEn) |-> rdNarrow == rdWide[127:0];
	endproperty
	a_alias: assert property (p_alias)
		else $error("narrow alias off");
endmodule : vafc_assertions

/* File: tb/vafc_sw_model.sv */
/*
 * Software side: latches the feature test made from an id answer.
 * Assumes idDone pulses once per answer on clk.
 */
`timescale 1ns/100ps

module vafc_sw_model #(
	parameter logic [31:0] STATE_MASK_A = 32'h6
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        idDone,
	input wire logic [31:0] idEbx,
	output logic            featureOk
);
	always_ff @(posedge clk) begin
		if (!rst_n)
			featureOk <= 1'b0;
		else if (idDone)
			featureOk <= (idEbx & 32'h20) == 32'h20
				&& (STATE_MASK_A & 32'h6) == 32'h6;
	end
endmodule : vafc_sw_model

/* File: tb/vector_align_fault_check_bench.sv */
/*
 * Self-checking bench for the vector alignment and fault checker.
 * Assumes the design files and the checker are compiled first.
 */
`timescale 1ns/100ps
`include "vafc_regs.svh"

module vector_align_fault_check_bench
	import vafc_pkg::*;
;
	logic clk, rst_n, accValid, flagAlignCheck, crAlignMask, fpValid, osEn;
	logic idValid, wrEn, wrWide, faultValid, idDone, featureOk;
	logic [5:0] accAddrLow, fpRaised, fpMask;
	logic [2:0] accSizeLog2;
	logic [1:0] privLevel;
	logic [31:0] idLeaf, idSubleaf, idEbx;
	logic [3:0] wrIdx, rdIdx;
	logic [255:0] wrData, rdWide;
	logic [127:0] rdNarrow;
	logic [15:0] faultCode;
	vafc_enc_t accEnc, wrEnc;
	vafc_cls_t accCls;
	vafc_fpsrc_t fpSrc;
	vafc_fault_t faultKind;
	int miscompares = 0;
	int check_count = 0;
	localparam logic [255:0] P = {32{8'ha5}};
	localparam logic [255:0] Q = {32{8'h3c}};
	// Short names keep scenario lines readable
	localparam vafc_enc_t   EL = VAFC_ENC_LEGACY;
	localparam vafc_enc_t   EP = VAFC_ENC_PREFIXED;
	localparam vafc_cls_t   CA = VAFC_CLS_ALIGNED_MOVE;
	localparam vafc_cls_t   CU = VAFC_CLS_UNALIGNED_MOVE;
	localparam vafc_cls_t   CR = VAFC_CLS_ARITH;
	localparam vafc_cls_t   CS = VAFC_CLS_SMALL;
	localparam vafc_fault_t KN = VAFC_FLT_NONE;
	localparam vafc_fault_t KG = VAFC_FLT_GP;
	localparam vafc_fault_t KA = VAFC_FLT_AC;
	localparam vafc_fault_t KX = VAFC_FLT_XM;
	localparam vafc_fault_t KU = VAFC_FLT_UD;

	vafc_top dut_u (.clk(clk), .rst_n(rst_n), .accValid(accValid),
		.accAddrLow(accAddrLow), .accEnc(accEnc), .accCls(accCls),
		.accSizeLog2(accSizeLog2), .flagAlignCheck(flagAlignCheck),
		.privLevel(privLevel), .crAlignMask(crAlignMask), .fpValid(fpValid),
		.fpSrc(fpSrc), .fpRaised(fpRaised), .fpMask(fpMask),
		.osSimdFpHandlerEnable(osEn), .idValid(idValid), .idLeaf(idLeaf),
		.idSubleaf(idSubleaf), .idEbx(idEbx), .idDone(idDone), .wrEn(wrEn),
		.wrIdx(wrIdx), .wrData(wrData), .wrWide(wrWide), .wrEnc(wrEnc),
		.rdIdx(rdIdx), .rdWide(rdWide), .rdNarrow(rdNarrow),
		.faultValid(faultValid), .faultKind(faultKind), .faultCode(faultCode));
	vafc_sw_model sw_u (.clk(clk), .rst_n(rst_n), .idDone(idDone),
		.idEbx(idEbx), .featureOk(featureOk));

	always #20 clk = ~clk;

	task automatic chk(input string n, input logic [255:0] e,
		input logic [255:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic answer(input vafc_fault_t k);
		chk("faultKind", 256'(k), 256'(faultKind));
		chk("faultValid", 256'(k != VAFC_FLT_NONE), 256'(faultValid));
		chk("faultCode", 256'h0, 256'(faultCode));
	endtask : answer
	task automatic acc(input logic [5:0] a, input vafc_enc_t e,
		input vafc_cls_t c, input logic [2:0] s, input vafc_fault_t k);
		@(posedge clk) #1;
		accAddrLow = a;
		accEnc = e;
		accCls = c;
		accSizeLog2 = s;
		accValid = 1'b1;
		@(posedge clk) #1;
		accValid = 1'b0;
		answer(k);
	endtask : acc
	task automatic fp(input vafc_fpsrc_t s, input logic [5:0] r,
		input logic [5:0] m, input logic o, input vafc_fault_t k);
		@(posedge clk) #1;
		fpSrc = s;
		fpRaised = r;
		fpMask = m;
		osEn = o;
		fpValid = 1'b1;
		@(posedge clk) #1;
		fpValid = 1'b0;
		answer(k);
	endtask : fp
	task automatic wr(input logic [3:0] i, input logic [255:0] d,
		input logic w, input vafc_enc_t e);
		@(posedge clk) #1;
		wrIdx = i;
		wrData = d;
		wrWide = w;
		wrEnc = e;
		wrEn = 1'b1;
		@(posedge clk) #1;
		wrEn = 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] i, input logic [255:0] e);
		rdIdx = i;
		@(posedge clk) #1;
		chk("rdWide", e, rdWide);
		chk("rdNarrow", 256'(e[127:0]), 256'(rdNarrow));
	endtask : rd

	initial begin
		#(2000 * 40);
		miscompares++;
		finish_test();
	end

	initial begin
		{clk, rst_n, accValid, fpValid, idValid, wrEn, wrWide, osEn} = '0;
		{flagAlignCheck, crAlignMask, privLevel, accAddrLow, accSizeLog2} = '0;
		{fpRaised, fpMask, idLeaf, idSubleaf, wrIdx, rdIdx, wrData} = '0;
		accEnc = EL;
		wrEnc = EL;
		accCls = CA;
		fpSrc = VAFC_FP_BASE;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) #1;
			idLeaf = (k == 2) ? 32'h1 : 32'h7;
			idSubleaf = 32'(k == 1);
			idValid = 1'b1;
			@(posedge clk) #1;
			idValid = 1'b0;
			chk("idDone", 256'h1, 256'(idDone));
			chk("idEbx", (k == 0) ? 256'h20 : '0, 256'(idEbx));
			if (k == 0) begin
				@(posedge clk) #1;
				chk("featureOk", 256'h1, 256'(featureOk));
			end
		end
		acc(6'h08, EL, CA, 3'h4, KG);
		acc(6'h10, EL, CA, 3'h4, KN);
		acc(6'h10, EP, CA, 3'h5, KG);
		acc(6'h20, EP, CA, 3'h5, KN);
		acc(6'h18, EP, CA, 3'h4, KG);
		acc(6'h01, EL, CU, 3'h4, KN);
		acc(6'h04, EL, CR, 3'h4, KG);
		acc(6'h03, EP, CR, 3'h5, KN);
		acc(6'h02, EL, CS, 3'h2, KN);
		{flagAlignCheck, crAlignMask, privLevel} = 4'hf;
		acc(6'h02, EL, CS, 3'h2, KA);
		acc(6'h04, EP, CS, 3'h3, KA);
		acc(6'h08, EP, CS, 3'h3, KN);
		acc(6'h01, EP, CU, 3'h5, KN);
		acc(6'h01, EL, CU, 3'h4, KN);
		acc(6'h01, EL, CR, 3'h4, KG);
		privLevel = 2'h0;
		acc(6'h01, EL, CS, 3'h1, KN);
		fp(VAFC_FP_BASE, 6'h01, 6'h00, 1'b1, KX);
		fp(VAFC_FP_BASE, 6'h01, 6'h01, 1'b1, KN);
		fp(VAFC_FP_BASE, 6'h02, 6'h01, 1'b0, KU);
		fp(VAFC_FP_CONV_FUSED, 6'h20, 6'h00, 1'b1, KX);
		fp(VAFC_FP_CONV_FUSED, 6'h20, 6'h00, 1'b0, KU);
		fp(VAFC_FP_SECOND_GEN, 6'h3f, 6'h00, 1'b1, KN);
		wr(4'h1, P, 1'b1, EP);
		rd(4'h1, P);
		wr(4'h1, Q, 1'b0, EL);
		rd(4'h1, {P[255:128], Q[127:0]});
		wr(4'h1, Q, 1'b0, EP);
		rd(4'h1, {128'h0, Q[127:0]});
		finish_test();
	end
endmodule : vector_align_fault_check_bench

bind vafc_top vafc_assertions #(.NUM_REGS(NUM_REGS), .FP_FLAGS(FP_FLAGS))
	chk_u (.clk(clk), .rst_n(rst_n), .accValid(accValid),
	.accAddrLow(accAddrLow), .accEnc(accEnc), .accCls(accCls),
	.accSizeLog2(accSizeLog2), .flagAlignCheck(flagAlignCheck),
	.privLevel(privLevel), .crAlignMask(crAlignMask), .fpValid(fpValid),
	.fpSrc(fpSrc), .fpRaised(fpRaised), .fpMask(fpMask),
	.osSimdFpHandlerEnable(osSimdFpHandlerEnable), .idValid(idValid),
	.idLeaf(idLeaf), .idSubleaf(idSubleaf), .idEbx(idEbx), .idDone(idDone),
	.wrEn(wrEn), .rdIdx(rdIdx), .rdWide(rdWide), .rdNarrow(rdNarrow),
	.faultValid(faultValid), .faultKind(faultKind), .faultCode(faultCode));
